// >>> logic/lsd_top.sv
`timescale 1ns/1ps
// How it works
// - Command bit 7 low means data follows
// - Drive mode sets panel on and bias
// - Panel off stops outputs at the end of the current frame
// - RAM pointer loads low five address bits
// - Address resets zero, invalid loads force zero
// - Address MSB bit stored, applied at next pointer load
// - Address auto-increments, wraps after 22h
// - Frame rate selects 512..768 source clocks
// - Drive field selects line or frame inversion
// - Drive field selects drive strength setting
// - Chip operation holds MSB, reset, clock source
// - Software reset restores initial state, except RAM and clock source
// - Clock source internal or external pin
// - Blink rate off, 0.5, 1, 2 Hz
// - Whole panel forces lit or dark
// - Override only when on; dark wins
// - State undefined until initialised
// - Bits on rising clock, byte on falling
// - Data mode holds until select rises
// - Partial nibble or command byte discarded
// - Software reset blanks panel, clears address
module lsd_top (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic chip_select_n,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic external_clock_pin,
	input wire logic blank_input_n,
	output logic [26:0] seg_out,
	output logic [3:0] com_out,
	output logic panel_drive,
	output logic drive_polarity,
	output logic panel_on,
	output logic bias_half,
	output logic frame_inversion,
	output logic [1:0] frame_rate,
	output logic [1:0] drive_strength,
	output logic clock_source_ext,
	output logic [1:0] flash_rate,
	output logic force_all_lit,
	output logic force_all_dark,
	output logic [5:0] ram_addr
);

	// ==========================================================
	// Input synchronisers
	logic [4:0] s_in;
	logic cs_high, s_sclk, s_sd, s_ext, s_blank_n;

	lsd_sync #(.W(5), .INIT(lsd_pkg::SYNC_INIT)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({blank_input_n, external_clock_pin, serial_data, serial_clk, chip_select_n}),
		.sync_out(s_in)
	);

	assign cs_high = s_in[0];
	assign s_sclk = s_in[1];
	assign s_sd = s_in[2];
	assign s_ext = s_in[3];
	assign s_blank_n = s_in[4];

	// ==========================================================
	// Link and command state
	lsd_pkg::lsd_link_e link_mode, next_link_mode, mode_now;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic sclk_d, sclk_rise, sclk_fall;
	logic addr_msb, next_addr_msb;
	logic sw_pulse, next_sw_pulse;
	logic next_panel_on, next_bias_half, next_frame_inversion, next_clock_source_ext;
	logic next_force_all_lit, next_force_all_dark;
	logic [1:0] next_frame_rate, next_drive_strength, next_flash_rate;
	logic [5:0] next_ram_addr;
	logic [3:0] ram [lsd_pkg::RAM_WORDS];
	logic [3:0] next_ram [lsd_pkg::RAM_WORDS];
	logic cmd_strobe, nib_commit;
	lsd_pkg::lsd_cmd_e cmd_kind;

	assign sclk_rise = s_sclk & ~sclk_d;
	assign sclk_fall = ~s_sclk & sclk_d;
	assign mode_now = (link_mode == lsd_pkg::LSD_LINK_IDLE) ? lsd_pkg::LSD_LINK_CMD : link_mode;
	assign cmd_strobe = ~cs_high & sclk_fall & (mode_now != lsd_pkg::LSD_LINK_DATA)
		& (bit_cnt == lsd_pkg::BITS_BYTE);
	assign nib_commit = ~cs_high & sclk_fall & (mode_now == lsd_pkg::LSD_LINK_DATA)
		& ((bit_cnt == lsd_pkg::BITS_NIBBLE) | (bit_cnt == lsd_pkg::BITS_BYTE));
	assign cmd_kind = lsd_pkg::lsd_cmd_kind(shreg);

	always_comb
	begin
		next_link_mode = link_mode;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_addr_msb = addr_msb;
		next_sw_pulse = 1'b0;
		next_panel_on = panel_on;
		next_bias_half = bias_half;
		next_frame_inversion = frame_inversion;
		next_clock_source_ext = clock_source_ext;
		next_force_all_lit = force_all_lit;
		next_force_all_dark = force_all_dark;
		next_frame_rate = frame_rate;
		next_drive_strength = drive_strength;
		next_flash_rate = flash_rate;
		next_ram_addr = ram_addr;
		next_ram = ram;
		if (cs_high)
		begin
			next_link_mode = lsd_pkg::LSD_LINK_IDLE;
			next_bit_cnt = 4'h0;
		end
		else
		begin
			next_link_mode = mode_now;
			if (sclk_rise)
			begin
				next_shreg = {shreg[6:0], s_sd};
				next_bit_cnt = bit_cnt + 4'h1;
			end
			else if (nib_commit)
			begin
				next_ram[ram_addr] = shreg[3:0];
				next_ram_addr = (ram_addr == lsd_pkg::RAM_LAST) ? 6'h00 : ram_addr + 6'h01;
				if (bit_cnt == lsd_pkg::BITS_BYTE)
					next_bit_cnt = 4'h0;
			end
			else if (cmd_strobe)
			begin
				next_bit_cnt = 4'h0;
				if (!shreg[7])
					next_link_mode = lsd_pkg::LSD_LINK_DATA;
				case (cmd_kind)
					lsd_pkg::LSD_CMD_MODE:
					begin
						next_panel_on = shreg[3];
						next_bias_half = shreg[2];
					end
					lsd_pkg::LSD_CMD_PTR:
						next_ram_addr = lsd_pkg::lsd_addr_fix({addr_msb, shreg[4:0]});
					lsd_pkg::LSD_CMD_DRIVE:
					begin
						next_frame_rate = shreg[4:3];
						next_frame_inversion = shreg[2];
						next_drive_strength = shreg[1:0];
					end
					lsd_pkg::LSD_CMD_CHIP:
					begin
						next_clock_source_ext = shreg[0];
						if (shreg[1])
						begin
							next_sw_pulse = 1'b1;
							next_addr_msb = 1'b0;
							next_panel_on = 1'b0;
							next_ram_addr = 6'h00;
							next_bias_half = 1'b0;
							next_frame_inversion = 1'b0;
							next_frame_rate = lsd_pkg::FRAME_RATE_RST;
							next_drive_strength = lsd_pkg::STRENGTH_RST;
							next_flash_rate = lsd_pkg::FLASH_RST;
							next_force_all_lit = 1'b0;
							next_force_all_dark = 1'b0;
						end
						else
							next_addr_msb = shreg[2];
					end
					lsd_pkg::LSD_CMD_FLASH:
						next_flash_rate = shreg[1:0];
					lsd_pkg::LSD_CMD_PANEL:
					begin
						next_force_all_lit = shreg[1];
						next_force_all_dark = shreg[0];
					end
					default:
						next_bit_cnt = 4'h0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			link_mode <= lsd_pkg::LSD_LINK_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			sclk_d <= 1'b0;
			addr_msb <= 1'b0;
			sw_pulse <= 1'b0;
			panel_on <= 1'b0;
			bias_half <= 1'b0;
			frame_inversion <= 1'b0;
			clock_source_ext <= 1'b0;
			force_all_lit <= 1'b0;
			force_all_dark <= 1'b0;
			frame_rate <= lsd_pkg::FRAME_RATE_RST;
			drive_strength <= lsd_pkg::STRENGTH_RST;
			flash_rate <= lsd_pkg::FLASH_RST;
			ram_addr <= 6'h00;
			for (int i = 0; i < lsd_pkg::RAM_WORDS; i++)
				ram[i] <= 4'h0;
		end
		else if (clk_en)
		begin
			link_mode <= next_link_mode;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			sclk_d <= s_sclk;
			addr_msb <= next_addr_msb;
			sw_pulse <= next_sw_pulse;
			panel_on <= next_panel_on;
			bias_half <= next_bias_half;
			frame_inversion <= next_frame_inversion;
			clock_source_ext <= next_clock_source_ext;
			force_all_lit <= next_force_all_lit;
			force_all_dark <= next_force_all_dark;
			frame_rate <= next_frame_rate;
			drive_strength <= next_drive_strength;
			flash_rate <= next_flash_rate;
			ram_addr <= next_ram_addr;
			ram <= next_ram;
		end
	end

	// ==========================================================
	// Frame scan, blink and drive outputs
	logic [11:0] osc_cnt, next_osc_cnt;
	logic ext_d, src_tick, frame_end;
	logic [7:0] qtr_cnt, next_qtr_cnt;
	logic [1:0] com_idx, next_com_idx;
	logic frame_par, next_frame_par;
	logic drive_active, next_drive_active;
	logic [7:0] blink_cnt, next_blink_cnt, blink_half;
	logic blink_phase, next_blink_phase;
	logic pol, en, pix;
	logic [26:0] next_seg;
	logic [3:0] next_com;

	assign src_tick = clock_source_ext ? (s_ext & ~ext_d) : (osc_cnt == lsd_pkg::OSC_DIV_LAST);
	assign frame_end = src_tick & (qtr_cnt >= lsd_pkg::lsd_qtr_len(frame_rate) - 8'h01)
		& (com_idx == 2'h3);

	always_comb
	begin
		next_osc_cnt = (osc_cnt == lsd_pkg::OSC_DIV_LAST) ? 12'h000 : osc_cnt + 12'h001;
		next_qtr_cnt = qtr_cnt;
		next_com_idx = com_idx;
		next_frame_par = frame_par;
		next_blink_cnt = blink_cnt;
		next_blink_phase = blink_phase;
		blink_half = lsd_pkg::FLASH_HALF_05HZ;
		pix = 1'b0;
		case (flash_rate)
			2'h2: blink_half = lsd_pkg::FLASH_HALF_1HZ;
			2'h3: blink_half = lsd_pkg::FLASH_HALF_2HZ;
			default: blink_half = lsd_pkg::FLASH_HALF_05HZ;
		endcase
		if (src_tick)
		begin
			if (qtr_cnt >= lsd_pkg::lsd_qtr_len(frame_rate) - 8'h01)
			begin
				next_qtr_cnt = 8'h00;
				next_com_idx = com_idx + 2'h1;
			end
			else
				next_qtr_cnt = qtr_cnt + 8'h01;
		end
		if (frame_end)
		begin
			next_frame_par = ~frame_par;
			if (blink_cnt + 8'h01 >= blink_half)
			begin
				next_blink_cnt = 8'h00;
				next_blink_phase = ~blink_phase;
			end
			else
				next_blink_cnt = blink_cnt + 8'h01;
		end
		if (flash_rate == 2'h0)
		begin
			next_blink_cnt = 8'h00;
			next_blink_phase = 1'b0;
		end
		if (sw_pulse)
			next_drive_active = 1'b0;
		else if (panel_on)
			next_drive_active = 1'b1;
		else if (frame_end)
			next_drive_active = 1'b0;
		else
			next_drive_active = drive_active;
		pol = frame_inversion ? frame_par : (frame_par ^ com_idx[0]);
		en = drive_active & s_blank_n;
		for (int i = 0; i < lsd_pkg::SEG_N; i++)
		begin
			pix = ram[i + lsd_pkg::SEG_FIRST][com_idx];
			if (force_all_dark)
				pix = 1'b0;
			else if (force_all_lit)
				pix = 1'b1;
			if (blink_phase)
				pix = 1'b0;
			next_seg[i] = en & (pix ^ pol);
		end
		next_com = en ? ((4'h1 << com_idx) ^ {lsd_pkg::COM_N{pol}}) : 4'h0;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			osc_cnt <= 12'h000;
			ext_d <= 1'b0;
			qtr_cnt <= 8'h00;
			com_idx <= 2'h0;
			frame_par <= 1'b0;
			drive_active <= 1'b0;
			blink_cnt <= 8'h00;
			blink_phase <= 1'b0;
			seg_out <= 27'h0000000;
			com_out <= 4'h0;
			panel_drive <= 1'b0;
			drive_polarity <= 1'b0;
		end
		else if (clk_en)
		begin
			osc_cnt <= next_osc_cnt;
			ext_d <= s_ext;
			qtr_cnt <= next_qtr_cnt;
			com_idx <= next_com_idx;
			frame_par <= next_frame_par;
			drive_active <= next_drive_active;
			blink_cnt <= next_blink_cnt;
			blink_phase <= next_blink_phase;
			seg_out <= next_seg;
			com_out <= next_com;
			panel_drive <= en;
			drive_polarity <= en & pol;
		end
	end

	// ==========================================================
	// Assertions
	a_addr_range: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		ram_addr <= lsd_pkg::RAM_LAST) else $error("RAM address out of range");
	a_addr_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		nib_commit && ram_addr == lsd_pkg::RAM_LAST |=> ram_addr == 6'h00) else $error("No wrap");
	a_addr_step: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		nib_commit && ram_addr != lsd_pkg::RAM_LAST |=> ram_addr == $past(ram_addr) + 6'h01)
		else $error("No increment");
	a_ptr_load: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		cmd_strobe && cmd_kind == lsd_pkg::LSD_CMD_PTR
		|=> ram_addr == lsd_pkg::lsd_addr_fix({$past(addr_msb), $past(shreg[4:0])}))
		else $error("Pointer load wrong");
	a_addr_hold: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		!nib_commit && !cmd_strobe |=> $stable(ram_addr)) else $error("Address moved");
	a_cs_clear: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		cs_high |=> bit_cnt == 4'h0 && link_mode == lsd_pkg::LSD_LINK_IDLE)
		else $error("Select high did not clear link");
	a_data_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		link_mode == lsd_pkg::LSD_LINK_DATA && !cs_high |=> link_mode == lsd_pkg::LSD_LINK_DATA)
		else $error("Left data mode");
	a_off_waits: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		drive_active && !panel_on && !frame_end && !sw_pulse |=> drive_active)
		else $error("Panel stopped before frame end");
	a_off_dark: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		!drive_active ##1 1 |-> seg_out == 27'h0000000 && com_out == 4'h0)
		else $error("Outputs active while off");
	a_dark_wins: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		force_all_dark && force_all_lit && drive_active && s_blank_n
		|=> seg_out == {lsd_pkg::SEG_N{drive_polarity}}) else $error("Dark did not win");
	a_soft_reset: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
		cmd_strobe && cmd_kind == lsd_pkg::LSD_CMD_CHIP && shreg[1]
		|=> !panel_on && ram_addr == 6'h00 && !addr_msb ##1 !drive_active)
		else $error("Software reset incomplete");

endmodule : lsd_top

// >>> logic/lsd_pkg.sv
package lsd_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 125_000_000;
	localparam int OSC_HZ = 40_960;
	localparam logic [11:0] OSC_DIV_LAST = 12'(CLK_HZ / OSC_HZ - 1);

	// ==========================================================
	// Display geometry and reset values
	localparam logic [5:0] RAM_LAST = 6'h22;
	localparam int RAM_WORDS = 35;
	localparam int SEG_FIRST = 4;
	localparam int SEG_N = 27;
	localparam int COM_N = 4;
	localparam logic [3:0] BITS_NIBBLE = 4'h4;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [1:0] FRAME_RATE_RST = 2'h0;
	localparam logic [1:0] STRENGTH_RST = 2'h2;
	localparam logic [1:0] FLASH_RST = 2'h0;
	localparam logic [4:0] SYNC_INIT = 5'h11;

	// Source ticks per common line: a frame is four of these
	localparam logic [7:0] QTR_80 = 8'h80;
	localparam logic [7:0] QTR_71 = 8'h90;
	localparam logic [7:0] QTR_64 = 8'ha2;
	localparam logic [7:0] QTR_53 = 8'hc0;

	// Frames per blink half period
	localparam logic [7:0] FLASH_HALF_2HZ = 8'h14;
	localparam logic [7:0] FLASH_HALF_1HZ = 8'h28;
	localparam logic [7:0] FLASH_HALF_05HZ = 8'h50;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		LSD_LINK_IDLE = 2'b00,
		LSD_LINK_CMD = 2'b01,
		LSD_LINK_DATA = 2'b10
	} lsd_link_e;

	typedef enum logic [2:0] {
		LSD_CMD_NONE = 3'b000,
		LSD_CMD_MODE = 3'b001,
		LSD_CMD_PTR = 3'b010,
		LSD_CMD_DRIVE = 3'b011,
		LSD_CMD_CHIP = 3'b100,
		LSD_CMD_FLASH = 3'b101,
		LSD_CMD_PANEL = 3'b110
	} lsd_cmd_e;

	// ==========================================================
	// Functions
	function automatic lsd_cmd_e lsd_cmd_kind(input logic [7:0] b);
		lsd_cmd_e k;
		k = LSD_CMD_NONE;
		casez (b[6:2])
			5'b00???: k = LSD_CMD_PTR;
			5'b01???: k = LSD_CMD_DRIVE;
			5'b10???: k = LSD_CMD_MODE;
			5'b1101?: k = LSD_CMD_CHIP;
			5'b1110?: k = LSD_CMD_FLASH;
			5'b11111: k = LSD_CMD_PANEL;
			default: k = LSD_CMD_NONE;
		endcase
		return k;
	endfunction : lsd_cmd_kind

	function automatic logic [5:0] lsd_addr_fix(input logic [5:0] a);
		return (a > RAM_LAST) ? 6'h00 : a;
	endfunction : lsd_addr_fix

	function automatic logic [7:0] lsd_qtr_len(input logic [1:0] rate);
		logic [7:0] q;
		q = QTR_80;
		case (rate)
			2'h1: q = QTR_71;
			2'h2: q = QTR_64;
			2'h3: q = QTR_53;
			default: q = QTR_80;
		endcase
		return q;
	endfunction : lsd_qtr_len

endpackage : lsd_pkg

// >>> logic/lsd_sync.sv
`timescale 1ns/1ps
module lsd_sync #(
	parameter int W = 5,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ==========================================================
	// Two-stage synchroniser
	logic [W-1:0] stage1;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stage1 <= INIT;
			sync_out <= INIT;
		end
		else if (clk_en)
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : lsd_sync

// >>> test/lsd_host.sv
`timescale 1ns/1ps
module lsd_host (
	input wire logic sys_clk,
	output logic chip_select_n,
	output logic serial_clk,
	output logic serial_data
);
	// ==========================================================
	// Idle link: deselected, serial clock parked low
	initial
	begin
		chip_select_n = 1'b1;
		serial_clk = 1'b0;
		serial_data = 1'b0;
	end

	// ==========================================================
	// Link tasks
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : hold

	// Select high then low clears the bit count before a frame
	task automatic open_frame();
		chip_select_n <= 1'b1;
		hold(4);
		chip_select_n <= 1'b0;
		hold(5);
	endtask : open_frame

	// Sends the top n bits of b, 40 ns low and 40 ns high per bit
	task automatic send_bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--)
		begin
			serial_data <= b[i];
			hold(5);
			serial_clk <= 1'b1;
			hold(5);
			serial_clk <= 1'b0;
		end
		hold(8);
	endtask : send_bits

	// Released data line shows the inverse of its last value
	task automatic close_frame();
		chip_select_n <= 1'b1;
		serial_data <= ~serial_data;
		hold(6);
	endtask : close_frame
endmodule : lsd_host

// >>> test/test_lcd_segment_command_decoder.sv
`timescale 1ns/1ps
module test_lcd_segment_command_decoder;
	logic sys_clk;
	logic sys_rst;
	logic clk_en;
	logic chip_select_n;
	logic serial_clk;
	logic serial_data;
	logic external_clock_pin;
	logic blank_input_n;
	logic [26:0] seg_out;
	logic [3:0] com_out;
	logic panel_drive;
	logic drive_polarity;
	logic panel_on;
	logic bias_half;
	logic frame_inversion;
	logic [1:0] frame_rate;
	logic [1:0] drive_strength;
	logic clock_source_ext;
	logic [1:0] flash_rate;
	logic force_all_lit;
	logic force_all_dark;
	logic [5:0] ram_addr;
	int err_total;
	int samples_checked;

	// ==========================================================
	// Clocks and units
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial
	begin
		external_clock_pin = 1'b0;
		forever
		begin
			repeat (4) @(posedge sys_clk);
			external_clock_pin <= ~external_clock_pin;
		end
	end

	lsd_host i_host (
		.sys_clk(sys_clk),
		.chip_select_n(chip_select_n),
		.serial_clk(serial_clk),
		.serial_data(serial_data)
	);

	lsd_top i_dut (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.chip_select_n(chip_select_n),
		.serial_clk(serial_clk),
		.serial_data(serial_data),
		.external_clock_pin(external_clock_pin),
		.blank_input_n(blank_input_n),
		.seg_out(seg_out),
		.com_out(com_out),
		.panel_drive(panel_drive),
		.drive_polarity(drive_polarity),
		.panel_on(panel_on),
		.bias_half(bias_half),
		.frame_inversion(frame_inversion),
		.frame_rate(frame_rate),
		.drive_strength(drive_strength),
		.clock_source_ext(clock_source_ext),
		.flash_rate(flash_rate),
		.force_all_lit(force_all_lit),
		.force_all_dark(force_all_dark),
		.ram_addr(ram_addr)
	);

	// ==========================================================
	// Tasks
	task automatic complete_run();
		$display("Checks made %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
		samples_checked++;
		if (seen !== want)
		begin
			$display("ERROR %0t %s seen %h want %h", $time, what, seen, want);
			err_total++;
		end
	endtask : check

	task automatic send(input logic [7:0] b);
		i_host.send_bits(b, 8);
	endtask : send

	// Bounded wait for the drive flag to reach a level
	task automatic wait_drive(input logic lvl, input int lim);
		int n;
		n = 0;
		while (panel_drive !== lvl && n < lim)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (panel_drive !== lvl)
		begin
			$display("ERROR %0t drive flag wait ran out", $time);
			err_total++;
			complete_run();
		end
	endtask : wait_drive

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [1:0] k;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		blank_input_n = 1'b1;
		err_total = 0;
		samples_checked = 0;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check(panel_on, 8'h00, "panel on");
		check(bias_half, 8'h00, "bias");
		check(frame_rate, 8'h00, "rate");
		check(frame_inversion, 8'h00, "inversion");
		check(drive_strength, 8'h02, "strength");
		check(clock_source_ext, 8'h00, "source");
		check(flash_rate, 8'h00, "flash");
		check(force_all_lit, 8'h00, "lit");
		check(force_all_dark, 8'h00, "dark");
		check(ram_addr, 8'h00, "addr");
		$display("Test reset values done");

		i_host.open_frame();
		send(8'hea);
		send(8'hcc);
		check(panel_on, 8'h01, "panel on");
		check(bias_half, 8'h01, "bias");
		for (int i = 0; i < 4; i++)
		begin
			k = 2'(i);
			send({3'b101, k, k[0], k});
			check(frame_rate, {6'h00, k}, "rate");
			check(frame_inversion, {7'h00, k[0]}, "inversion");
			check(drive_strength, {6'h00, k}, "strength");
			send({6'b111100, k});
			check(flash_rate, {6'h00, k}, "flash");
			send({6'b111111, k});
			check(force_all_lit, {7'h00, k[1]}, "lit");
			check(force_all_dark, {7'h00, k[0]}, "dark");
		end
		check({7'h00, seg_out == {27{drive_polarity}}}, 8'h01, "dark wins");
		check({7'h00, $onehot(com_out ^ {4{drive_polarity}})}, 8'h01, "one common");
		send(8'hfe);
		check({7'h00, seg_out == {27{~drive_polarity}}}, 8'h01, "all lit");
		blank_input_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		check({7'h00, seg_out == 27'h0000000 && com_out == 4'h0}, 8'h01, "blanked");
		blank_input_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		check(panel_drive, 8'h01, "unblanked");
		$display("Test command fields done");

		send(8'h85);
		check(ram_addr, 8'h05, "pointer");
		send(8'hec);
		check(ram_addr, 8'h05, "msb only stored");
		send(8'h82);
		check(ram_addr, 8'h22, "pointer msb");
		send(8'h83);
		check(ram_addr, 8'h00, "invalid pointer");
		send(8'h01);
		check(ram_addr, 8'h21, "pointer data");
		send(8'ha5);
		check(ram_addr, 8'h00, "wrap");
		send(8'h93);
		check(ram_addr, 8'h02, "data mode kept");
		i_host.send_bits(8'hff, 2);
		i_host.close_frame();
		check(ram_addr, 8'h02, "partial nibble");
		i_host.open_frame();
		i_host.send_bits(8'hc0, 5);
		i_host.close_frame();
		check(panel_on, 8'h01, "partial command");
		$display("Test address and data done");

		i_host.open_frame();
		send(8'he9);
		check(clock_source_ext, 8'h01, "source");
		wait_drive(1'b1, 50);
		send(8'hc0);
		check(panel_on, 8'h00, "panel off");
		wait_drive(1'b0, 6400);
		send(8'hcc);
		wait_drive(1'b1, 50);
		send(8'hee);
		check(panel_on, 8'h00, "soft reset panel");
		check(panel_drive, 8'h00, "soft reset drive");
		check(ram_addr, 8'h00, "soft reset addr");
		check(bias_half, 8'h00, "soft reset bias");
		check(clock_source_ext, 8'h00, "soft reset source");
		check(drive_strength, 8'h02, "soft reset strength");
		send(8'h85);
		check(ram_addr, 8'h05, "msb ignored");
		i_host.close_frame();
		$display("Test panel and soft reset done");
		complete_run();
	end
endmodule : test_lcd_segment_command_decoder
